// [design/bmsp_pkg.sv]
package bmsp_pkg;
   localparam int CLK_KHZ = 250000;
   localparam int TX_SHUT_NS = 4000;
   localparam int TX_SHUT_CYC = (TX_SHUT_NS * (CLK_KHZ / 1000) + 999) / 1000;
   localparam int SHUT_W = 10;
   localparam int HALF_W = 8;
   localparam int RATE_1_KBPS = 1000;
   localparam int RATE_2_KBPS = 2000;
   localparam int RATE_5_KBPS = 5500;
   localparam int RATE_11_KBPS = 11000;
   localparam logic [1:0] RATE_SEL_1 = 2'h0;
   localparam logic [1:0] RATE_SEL_2 = 2'h1;
   localparam logic [1:0] RATE_SEL_5 = 2'h2;
   localparam logic [1:0] RATE_SEL_11 = 2'h3;
   localparam logic [SHUT_W-1:0] SHUT_LAST = SHUT_W'(TX_SHUT_CYC - 1);

   typedef enum logic [3:0] {
      TX_IDLE = 4'h1, TX_HEADER = 4'h2, TX_PAYLOAD = 4'h4, TX_SHUT = 4'h8
   } bmsp_tx_e;
   typedef enum logic [3:0] {
      RX_IDLE = 4'h1, RX_WAIT = 4'h2, RX_LOW = 4'h4, RX_HIGH = 4'h8
   } bmsp_rx_e;
   typedef enum logic [1:0] {
      CCA_ENERGY = 2'h0, CCA_CARRIER = 2'h1, CCA_BOTH = 2'h2, CCA_EITHER = 2'h3
   } bmsp_cca_e;

   typedef struct packed {
      logic txSampleFall;
      logic [1:0] txRate;
      logic rxClkInvert;
      bmsp_cca_e ccaAlgo;
      logic ccaInvert;
      logic diversityOn;
   } bmsp_cfg_s;

   typedef struct packed {
      logic txEnMeta;
      logic txEnSync;
      logic txEnPrev;
      logic txDatMeta;
      logic txDatSync;
      logic rxEnMeta;
      logic rxEnSync;
      bmsp_tx_e txState;
      logic [SHUT_W-1:0] shutCnt;
      logic [HALF_W-1:0] txHalf;
      logic [1:0] txRate;
      logic transmit_bit_clock;
      logic txReady;
      logic txBitValid;
      logic txBit;
      bmsp_rx_e rxState;
      logic [HALF_W-1:0] rxHalf;
      logic receive_bit_clock;
      logic rxPinClk;
      logic rxData;
      logic frameValid;
      logic antenna_select;
      logic antSelN;
      logic cca;
   } bmsp_state_s;

   localparam bmsp_state_s ST_RESET = '{txState: TX_IDLE, rxState: RX_IDLE,
      antSelN: 1'b1, default: '0};

   // Gives the last count of a half bit period for a rate selection.
   function automatic logic [HALF_W-1:0] halfLast(input logic [1:0] rate);
      int kbps;
      case (rate)
         RATE_SEL_1: kbps = RATE_1_KBPS;
         RATE_SEL_2: kbps = RATE_2_KBPS;
         RATE_SEL_5: kbps = RATE_5_KBPS;
         default: kbps = RATE_11_KBPS;
      endcase
      return HALF_W'(CLK_KHZ / (2 * kbps) - 1);
   endfunction : halfLast
endpackage : bmsp_pkg

// [design/bmsp_port.sv]
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Receive bit buffer with flush.
module bmsp_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;
   logic full;
   logic empty;

   assign empty = (wrPtr_q == rdPtr_q);
   assign full = (wrPtr_q[AW] != rdPtr_q[AW]) &&
      (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[rdPtr_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (inValid && !full) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule : bmsp_fifo

////////////////////////////////////////////////////////////////////////////////
// Serial data port between baseband and MAC.
module bmsp_port #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire bmsp_pkg::bmsp_cfg_s cfg,
   input wire logic transmitEnable,
   input wire logic txSerialData,
   input wire logic preambleDone,
   output logic txOperational,
   output logic txReady,
   output logic transmitBitClock,
   output logic txBitValid,
   output logic txBit,
   input wire logic energyAbove,
   input wire logic carrierSense,
   output logic channelClearFlag,
   input wire logic antennaSwitch,
   output logic antennaSelect,
   output logic antennaSelectN,
   input wire logic receiveEnable,
   input wire logic [1:0] rxRate,
   input wire logic sfdDetected,
   input wire logic headerError,
   input wire logic crcActive,
   input wire logic demodValid,
   input wire logic demodBit,
   output logic demodReady,
   output logic rxOperational,
   output logic receiveBitClock,
   output logic rxSerialData,
   output logic receiveFrameValid
);
   bmsp_pkg::bmsp_state_s s_q;
   bmsp_pkg::bmsp_state_s s_d;
   logic txRise;
   logic txFall;
   logic busy;
   logic rxPop;
   logic rxFlush;
   logic fifoInReady;
   logic fifoValid;
   logic fifoBit;

   assign txRise = s_q.txEnSync && !s_q.txEnPrev;
   assign txFall = !s_q.txEnSync && s_q.txEnPrev;
   assign demodReady = fifoInReady && s_q.rxEnSync;

   bmsp_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .flush(rxFlush),
      .inValid(demodValid && demodReady),
      .inReady(fifoInReady),
      .inData(demodBit),
      .outValid(fifoValid),
      .outReady(rxPop),
      .outData(fifoBit)
   );

   /////////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      s_d = s_q;
      rxPop = 1'b0;
      rxFlush = 1'b0;
      // Two flip-flop synchronizers for the MAC inputs.
      s_d.txEnMeta = transmitEnable;
      s_d.txEnSync = s_q.txEnMeta;
      s_d.txEnPrev = s_q.txEnSync;
      s_d.txDatMeta = txSerialData;
      s_d.txDatSync = s_q.txDatMeta;
      s_d.rxEnMeta = receiveEnable;
      s_d.rxEnSync = s_q.rxEnMeta;
      s_d.txBitValid = 1'b0;
      // Transmit bit clock runs while the transmitter is active.
      if (s_q.txState != bmsp_pkg::TX_IDLE) begin
         if (s_q.txHalf == bmsp_pkg::halfLast(s_q.txRate)) begin
            s_d.txHalf = '0;
            s_d.transmit_bit_clock = !s_q.transmit_bit_clock;
            if (s_q.txReady &&
               (cfg.txSampleFall ? s_q.transmit_bit_clock : !s_q.transmit_bit_clock)) begin
               s_d.txBitValid = 1'b1;
               s_d.txBit = s_q.txDatSync;
            end
         end else begin
            s_d.txHalf = s_q.txHalf + 1'b1;
         end
      end
      case (s_q.txState)
         bmsp_pkg::TX_IDLE: begin
            s_d.transmit_bit_clock = 1'b0;
            s_d.txHalf = '0;
            if (txRise) begin
               s_d.txState = bmsp_pkg::TX_HEADER;
               s_d.txRate = cfg.txRate;
            end
         end
         bmsp_pkg::TX_HEADER: begin
            if (txFall) begin
               s_d.txState = bmsp_pkg::TX_SHUT;
               s_d.shutCnt = '0;
            end else if (preambleDone) begin
               s_d.txState = bmsp_pkg::TX_PAYLOAD;
               s_d.txReady = 1'b1;
            end
         end
         bmsp_pkg::TX_PAYLOAD: begin
            if (txFall) begin
               s_d.txState = bmsp_pkg::TX_SHUT;
               s_d.shutCnt = '0;
            end
         end
         bmsp_pkg::TX_SHUT: begin
            if (s_q.shutCnt == bmsp_pkg::SHUT_LAST) begin
               s_d.txState = bmsp_pkg::TX_IDLE;
               s_d.txReady = 1'b0;
               s_d.transmit_bit_clock = 1'b0;
            end else begin
               s_d.shutCnt = s_q.shutCnt + 1'b1;
            end
         end
         default: begin
            s_d.txState = bmsp_pkg::TX_IDLE;
            s_d.txReady = 1'b0;
         end
      endcase
      // Receive framing and bit clock.
      case (s_q.rxState)
         bmsp_pkg::RX_IDLE: begin
            if (sfdDetected) begin
               s_d.rxState = bmsp_pkg::RX_WAIT;
            end
         end
         bmsp_pkg::RX_WAIT: begin
            if (fifoValid && !crcActive) begin
               rxPop = 1'b1;
               s_d.rxData = fifoBit;
               s_d.frameValid = 1'b1;
               s_d.rxHalf = '0;
               s_d.rxState = bmsp_pkg::RX_LOW;
            end
         end
         bmsp_pkg::RX_LOW: begin
            if (s_q.rxHalf == bmsp_pkg::halfLast(rxRate)) begin
               s_d.rxHalf = '0;
               s_d.receive_bit_clock = 1'b1;
               s_d.rxState = bmsp_pkg::RX_HIGH;
            end else begin
               s_d.rxHalf = s_q.rxHalf + 1'b1;
            end
         end
         bmsp_pkg::RX_HIGH: begin
            if (s_q.rxHalf == bmsp_pkg::halfLast(rxRate)) begin
               s_d.rxHalf = '0;
               s_d.receive_bit_clock = 1'b0;
               s_d.rxState = bmsp_pkg::RX_WAIT;
            end else begin
               s_d.rxHalf = s_q.rxHalf + 1'b1;
            end
         end
         default: begin
            s_d.rxState = bmsp_pkg::RX_IDLE;
         end
      endcase
      if (!s_q.rxEnSync || headerError) begin
         rxPop = 1'b0;
         rxFlush = 1'b1;
         s_d.rxState = bmsp_pkg::RX_IDLE;
         s_d.frameValid = 1'b0;
         s_d.receive_bit_clock = 1'b0;
         s_d.rxHalf = '0;
      end
      s_d.rxPinClk = crcActive ? 1'b0 :
         (s_d.receive_bit_clock ^ cfg.rxClkInvert);
      // Antenna diversity and clear channel.
      if (antennaSwitch && cfg.diversityOn && s_q.rxEnSync) begin
         s_d.antenna_select = !s_q.antenna_select;
      end
      s_d.antSelN = !s_d.antenna_select;
      case (cfg.ccaAlgo)
         bmsp_pkg::CCA_ENERGY: busy = energyAbove;
         bmsp_pkg::CCA_CARRIER: busy = carrierSense;
         bmsp_pkg::CCA_BOTH: busy = energyAbove && carrierSense;
         default: busy = energyAbove || carrierSense;
      endcase
      s_d.cca = busy ^ cfg.ccaInvert;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= bmsp_pkg::ST_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign txOperational = (s_q.txState != bmsp_pkg::TX_IDLE);
   assign txReady = s_q.txReady;
   assign transmitBitClock = s_q.transmit_bit_clock;
   assign txBitValid = s_q.txBitValid;
   assign txBit = s_q.txBit;
   assign channelClearFlag = s_q.cca;
   assign antennaSelect = s_q.antenna_select;
   assign antennaSelectN = s_q.antSelN;
   assign rxOperational = s_q.rxEnSync;
   assign receiveBitClock = s_q.rxPinClk;
   assign rxSerialData = s_q.rxData;
   assign receiveFrameValid = s_q.frameValid;

   /////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_antComplement;
      @(posedge clk) disable iff (rst) antennaSelectN == !antennaSelect;
   endproperty
   a_antComplement: assert property (p_antComplement)
      else $error("Antenna outputs are not complementary.");

   property p_txStart;
      @(posedge clk) disable iff (rst)
         (s_q.txState == bmsp_pkg::TX_IDLE) && txRise |=>
         txOperational && !txReady;
   endproperty
   a_txStart: assert property (p_txStart)
      else $error("Enable rise did not start the transmitter.");

   property p_shutHold;
      @(posedge clk) disable iff (rst)
         (s_q.txState == bmsp_pkg::TX_SHUT) && (s_q.shutCnt == '0) |->
         txOperational [*8];
   endproperty
   a_shutHold: assert property (p_shutHold)
      else $error("Transmitter stopped too early after enable fell.");

   property p_shutEnd;
      @(posedge clk) disable iff (rst)
         (s_q.txState == bmsp_pkg::TX_SHUT) &&
         (s_q.shutCnt == bmsp_pkg::SHUT_LAST) |=>
         !txOperational && !txReady && !transmitBitClock;
   endproperty
   a_shutEnd: assert property (p_shutEnd)
      else $error("Shutdown end did not stop the transmitter.");

   property p_readyAfterHeader;
      @(posedge clk) disable iff (rst)
         $rose(txReady) |-> $past(preambleDone) && $past(s_q.txEnPrev);
   endproperty
   a_readyAfterHeader: assert property (p_readyAfterHeader)
      else $error("Ready rose without header completion.");

   property p_sampleEdge;
      @(posedge clk) disable iff (rst)
         txBitValid |-> (transmitBitClock != $past(transmitBitClock)) &&
         (transmitBitClock == !$past(cfg.txSampleFall));
   endproperty
   a_sampleEdge: assert property (p_sampleEdge)
      else $error("Transmit data sampled on the wrong clock edge.");

   property p_ccaPolarity;
      @(posedge clk) disable iff (rst)
         (cfg.ccaAlgo == bmsp_pkg::CCA_ENERGY) && !energyAbove |=>
         channelClearFlag == $past(cfg.ccaInvert);
   endproperty
   a_ccaPolarity: assert property (p_ccaPolarity)
      else $error("Clear channel flag polarity is wrong.");

   property p_crcLow;
      @(posedge clk) disable iff (rst) crcActive |=> !receiveBitClock;
   endproperty
   a_crcLow: assert property (p_crcLow)
      else $error("Receive clock toggled during header CRC.");

   property p_idleQuiet;
      @(posedge clk) disable iff (rst)
         (s_q.rxState == bmsp_pkg::RX_IDLE) |->
         !receiveFrameValid && !s_q.receive_bit_clock;
   endproperty
   a_idleQuiet: assert property (p_idleQuiet)
      else $error("Receive clock or frame valid active before delimiter.");

   property p_frameDrop;
      @(posedge clk) disable iff (rst)
         headerError || !s_q.rxEnSync |=> !receiveFrameValid;
   endproperty
   a_frameDrop: assert property (p_frameDrop)
      else $error("Frame valid stayed high after error or disable.");

   property p_firstBit;
      @(posedge clk) disable iff (rst)
         $rose(receiveFrameValid) |-> !s_q.receive_bit_clock && $past(rxPop) &&
         (rxSerialData == $past(fifoBit));
   endproperty
   a_firstBit: assert property (p_firstBit)
      else $error("First receive bit not aligned with frame valid.");
endmodule : bmsp_port

`default_nettype wire

// [bench/bmsp_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none

module bmsp_mac_model (
   input wire logic clk,
   input wire logic txReady,
   input wire logic transmitBitClock,
   input wire logic sampleFall,
   input wire logic receiveBitClock,
   input wire logic rxClkInvert,
   input wire logic rxSerialData,
   input wire logic receiveFrameValid,
   output logic transmitEnable,
   output logic txSerialData
);
   logic rxSeen[$];
   logic macClk;

   initial begin
      transmitEnable = 1'b0;
      txSerialData = 1'b0;
   end

   assign macClk = receiveBitClock ^ rxClkInvert;

   ////////////////////////////////////////////////////////////////////////////
   // Captures receive data on the rising edge that the MAC sees.
   always @(posedge macClk) begin
      if (receiveFrameValid === 1'b1) begin
         rxSeen.push_back(rxSerialData);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sends one byte and holds enable over the whole sequence.
   task automatic sendByte(input logic [7:0] b);
      logic rdy;
      logic lastClk;
      int i;
      @(posedge clk);
      #1;
      transmitEnable = 1'b1;
      txSerialData = b[0];
      rdy = 1'b0;
      lastClk = transmitBitClock;
      i = 0;
      while (i < 8) begin
         @(posedge clk);
         #1;
         if (rdy && (transmitBitClock != lastClk) &&
               (transmitBitClock == !sampleFall)) begin
            i++;
            txSerialData = (i < 8) ? b[i] : !b[7];
         end
         rdy = txReady;
         lastClk = transmitBitClock;
      end
      transmitEnable = 1'b0;
   endtask : sendByte
endmodule : bmsp_mac_model

`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk, rst, preambleDone, txOperational, txReady, transmitBitClock;
   logic transmitEnable, txSerialData, txBitValid, txBit, energyAbove;
   logic carrierSense, channelClearFlag, antennaSwitch, antennaSelect;
   logic antennaSelectN, receiveEnable, sfdDetected, headerError, crcActive;
   logic demodValid, demodBit, demodReady, rxOperational, receiveBitClock;
   logic rxSerialData, receiveFrameValid;
   logic [1:0] rxRate;
   bmsp_pkg::bmsp_cfg_s cfg;
   logic txBits[$];
   int fail_count = 0;
   int total_checks = 0;
   int seed = 32'h0710_ead9;

   bmsp_port #(.FIFO_DEPTH(8)) bmsp_port_inst (.clk(clk), .rst(rst),
      .cfg(cfg), .transmitEnable(transmitEnable),
      .txSerialData(txSerialData), .preambleDone(preambleDone),
      .txOperational(txOperational), .txReady(txReady),
      .transmitBitClock(transmitBitClock), .txBitValid(txBitValid),
      .txBit(txBit), .energyAbove(energyAbove), .carrierSense(carrierSense),
      .channelClearFlag(channelClearFlag), .antennaSwitch(antennaSwitch),
      .antennaSelect(antennaSelect), .antennaSelectN(antennaSelectN),
      .receiveEnable(receiveEnable), .rxRate(rxRate),
      .sfdDetected(sfdDetected), .headerError(headerError),
      .crcActive(crcActive), .demodValid(demodValid), .demodBit(demodBit),
      .demodReady(demodReady), .rxOperational(rxOperational),
      .receiveBitClock(receiveBitClock), .rxSerialData(rxSerialData),
      .receiveFrameValid(receiveFrameValid));

   bmsp_mac_model mac_inst (.clk(clk), .txReady(txReady),
      .transmitBitClock(transmitBitClock), .sampleFall(cfg.txSampleFall),
      .receiveBitClock(receiveBitClock), .rxClkInvert(cfg.rxClkInvert),
      .rxSerialData(rxSerialData), .receiveFrameValid(receiveFrameValid),
      .transmitEnable(transmitEnable), .txSerialData(txSerialData));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(negedge clk) begin
      if (txBitValid === 1'b1) begin
         txBits.push_back(txBit);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   function automatic int halfOf(input logic [1:0] r);
      int kbps[4];
      kbps = '{bmsp_pkg::RATE_1_KBPS, bmsp_pkg::RATE_2_KBPS,
         bmsp_pkg::RATE_5_KBPS, bmsp_pkg::RATE_11_KBPS};
      return bmsp_pkg::CLK_KHZ / (2 * kbps[r]);
   endfunction : halfOf

   ////////////////////////////////////////////////////////////////////////////
   task automatic ccaTest;
      logic busy;
      for (int k = 0; k < 32; k++) begin
         cfg.ccaAlgo = bmsp_pkg::bmsp_cca_e'(k[1:0]);
         cfg.ccaInvert = k[2];
         {energyAbove, carrierSense} = 2'($random(seed));
         tick(2);
         case (k[1:0])
            2'h0: busy = energyAbove;
            2'h1: busy = carrierSense;
            2'h2: busy = energyAbove & carrierSense;
            default: busy = energyAbove | carrierSense;
         endcase
         chk("channelClearFlag", channelClearFlag, busy ^ k[2]);
      end
   endtask : ccaTest

   task automatic antTest;
      logic prev;
      receiveEnable = 1'b1;
      tick(4);
      for (int k = 0; k < 4; k++) begin
         cfg.diversityOn = k[0];
         prev = antennaSelect;
         antennaSwitch = 1'b1;
         tick(1);
         antennaSwitch = 1'b0;
         tick(1);
         chk("antennaSelect", antennaSelect, prev ^ k[0]);
         chk("antennaSelectN", antennaSelectN, !(prev ^ k[0]));
      end
      receiveEnable = 1'b0;
      tick(4);
   endtask : antTest

   task automatic txTest(input logic [1:0] rate, input logic fall);
      logic [7:0] b;
      int n;
      b = 8'($random(seed));
      cfg.txRate = rate;
      cfg.txSampleFall = fall;
      txBits.delete();
      chk("txOperational idle", txOperational, 1'b0);
      fork
         mac_inst.sendByte(b);
      join_none
      n = 0;
      while (txOperational !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("tx start", n >= 2 && n <= 6, 1'b1);
      chk("txReady early", txReady, 1'b0);
      tick(10);
      preambleDone = 1'b1;
      tick(1);
      preambleDone = 1'b0;
      tick(1);
      chk("txReady", txReady, 1'b1);
      @(posedge transmitBitClock);
      tick(1);
      n = 1;
      while (transmitBitClock === 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      chk("tx half period", n, halfOf(rate));
      wait (mac_inst.transmitEnable === 1'b0);
      n = 0;
      while (txOperational === 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk("tx shutdown", n >= bmsp_pkg::TX_SHUT_CYC &&
         n <= bmsp_pkg::TX_SHUT_CYC + 6, 1'b1);
      chk("txReady end", txReady, 1'b0);
      chk("tx clock end", transmitBitClock, 1'b0);
      for (int i = 0; i < 8; i++) begin
         chk("tx bit", txBits[i], b[i]);
      end
   endtask : txTest

   task automatic rxTest(input logic inv);
      logic [11:0] bits;
      int n;
      int m;
      bits = 12'($random(seed));
      rxRate = 2'($random(seed));
      cfg.rxClkInvert = inv;
      mac_inst.rxSeen.delete();
      receiveEnable = 1'b1;
      tick(4);
      chk("rxOperational", rxOperational, 1'b1);
      chk("rx clock idle", receiveBitClock, inv);
      sfdDetected = 1'b1;
      tick(1);
      sfdDetected = 1'b0;
      crcActive = 1'b1;
      demodValid = 1'b1;
      demodBit = bits[0];
      tick(1);
      demodValid = 1'b0;
      tick(1);
      repeat (20) begin
         chk("rx clock crc", receiveBitClock, 1'b0);
         chk("frame valid crc", receiveFrameValid, 1'b0);
         tick(1);
      end
      crcActive = 1'b0;
      n = 0;
      fork
         begin
            demodValid = 1'b1;
            for (int i = 1; i < 12; i++) begin
               demodBit = bits[i];
               while (demodReady !== 1'b1 && n < 9000) begin
                  tick(1);
                  n++;
               end
               tick(1);
            end
            demodValid = 1'b0;
         end
         begin
            wait (receiveFrameValid === 1'b1);
            #1;
            chk("first bit", rxSerialData, bits[0]);
            @(posedge mac_inst.macClk);
            tick(1);
            m = 1;
            while (mac_inst.macClk === 1'b1 && m < 300) begin
               tick(1);
               m++;
            end
            chk("rx half period", m, halfOf(rxRate));
         end
      join
      chk("fifo refused", n > 0, 1'b1);
      n = 0;
      while (mac_inst.rxSeen.size() < 12 && n < 5000) begin
         tick(1);
         n++;
      end
      for (int i = 0; i < 12; i++) begin
         chk("rx bit", mac_inst.rxSeen[i], bits[i]);
      end
      chk("frame valid held", receiveFrameValid, 1'b1);
      headerError = 1'b1;
      tick(1);
      headerError = 1'b0;
      tick(1);
      chk("frame valid error", receiveFrameValid, 1'b0);
      receiveEnable = 1'b0;
      tick(4);
      chk("rx standby", rxOperational, 1'b0);
      chk("rx standby ready", demodReady, 1'b0);
   endtask : rxTest

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      cfg = '0;
      {preambleDone, energyAbove, carrierSense, antennaSwitch} = 4'h0;
      {receiveEnable, sfdDetected, headerError, crcActive} = 4'h0;
      {demodValid, demodBit} = 2'h0;
      rxRate = 2'h3;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      tick(3);
      chk("antennaSelectN reset", antennaSelectN, 1'b1);
      ccaTest();
      $display("test cca done");
      antTest();
      $display("test antenna done");
      for (int r = 0; r < 4; r++) begin
         txTest(2'(r), r[0]);
         $display("test transmit rate %0d done", r);
      end
      rxTest(1'b0);
      $display("test receive normal clock done");
      rxTest(1'b1);
      $display("test receive inverted clock done");
      report_and_stop();
   end

   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
endmodule : tb_top

`default_nettype wire
